// ==== hdl/scpt_top.sv ====
/*
  System clock prescaler with protected two-step update, RC oscillator
  trim register, start-up delay sequencer, clock output pin and timer
  oscillator enable logic, with an Avalon-MM slave.
  Assumes configuration straps on fuse_i are static and held through
  reset, and that wake pulses come from logic on clock_i.
*/
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "scpt_params.svh"

module scpt_top #(
  parameter int UNLOCK_CYCLES = `SCPT_UNLOCK_CYCLES,
  parameter int SHORT_DLY_CYCLES = `SCPT_CLK_HZ / 1000000 * `SCPT_DLY_SHORT_US,
  parameter int LONG_DLY_CYCLES = `SCPT_CLK_HZ / 1000000 * `SCPT_DLY_LONG_US,
  parameter int RC_HZ = `SCPT_RC_HZ,
  parameter int TOSC_HZ = `SCPT_TOSC_HZ
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire scpt_pkg::scpt_fuse_t fuse_i,
  input wire logic deep_sleep_wake_i,
  input wire logic port_pin_data_i,
  output scpt_pkg::scpt_domains_t domain_clock_enable_o,
  output logic core_clock_o,
  output logic clock_output_pin_o,
  output logic clock_output_override_o,
  output scpt_pkg::scpt_trim_t rc_oscillator_trim_o,
  output logic timer_osc_enable_o,
  output logic timer_external_clock_select_o,
  output logic startup_done_o
);
  import scpt_pkg::*;

  localparam int DLY_MAX = (1 << `SCPT_DLY_W) - 1;

  // Elaboration checks on what the counters can hold and that the oscillator frequencies are positive
  if (UNLOCK_CYCLES < 1 || UNLOCK_CYCLES > 15) begin : g_bad_unlock
    $error("UNLOCK_CYCLES must be 1 to 15");
  end
  if (SHORT_DLY_CYCLES < 0 || SHORT_DLY_CYCLES + `SCPT_RESET_CK > DLY_MAX ||
      LONG_DLY_CYCLES < 0 || LONG_DLY_CYCLES + `SCPT_RESET_CK > DLY_MAX) begin : g_bad_delay
    $error("start-up delay does not fit the delay counter");
  end
  if (RC_HZ < 1 || TOSC_HZ < 1) begin : g_bad_osc
    $error("oscillator frequencies must be positive");
  end

  scpt_state_t q_reg;
  scpt_state_t q_next;
  logic div_tick;
  logic div_clock;
  logic req;
  logic wr_fire;
  logic [7:0] wd;
  logic tosc_allowed;

  // Word-aligned register hit on the byte address
  function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
    reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : reg_hit

  // Delay counter load for a start-up code: the total start-up cycles after reset, less one
  function automatic logic [`SCPT_DLY_W-1:0] reset_delay(input logic [1:0] code);
    int total;
    total = `SCPT_RESET_CK;
    unique case (code)
      2'b00: total = `SCPT_RESET_CK;
      2'b01: total = `SCPT_RESET_CK + SHORT_DLY_CYCLES;
      // Reserved code takes the longest, safest delay
      default: total = `SCPT_RESET_CK + LONG_DLY_CYCLES;
    endcase
    reset_delay = `SCPT_DLY_W'(total - 1);
  endfunction : reset_delay

  // Divided RC clock is at least four times the timer oscillator
  function automatic logic tosc_rate_ok(input logic [3:0] code);
    tosc_rate_ok = (RC_HZ >> code) >= (`SCPT_TOSC_RATIO * TOSC_HZ);
  endfunction : tosc_rate_ok

  function automatic logic [7:0] read_value(input logic [9:0] addr, input scpt_state_t s,
                                            input logic allowed);
    read_value = 8'h00;
    if (reg_hit(addr, `SCPT_IDX_PRESCALE)) begin
      read_value = {s.unlock, 3'b000, s.sel};
    end else if (reg_hit(addr, `SCPT_IDX_TRIM)) begin
      read_value = s.trim;
    end else if (reg_hit(addr, `SCPT_IDX_CONFIG)) begin
      read_value = {6'h00, s.tosc_ext, s.tosc_req};
    end else if (reg_hit(addr, `SCPT_IDX_STATUS)) begin
      read_value = {s.unlock, s.fuse.divide_by_eight_config, s.fuse.startup_time_config,
                    s.fuse.clock_output_config, s.fuse.rc_is_system_clock, allowed,
                    (s.st == ST_RUN)};
    end
  endfunction : read_value

  scpt_divider u_divider (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .select_i(q_reg.sel),
    .tick_o(div_tick),
    .div_clock_o(div_clock)
  );

  assign req = avs_read_i | avs_write_i;
  assign wr_fire = avs_write_i & q_reg.ack & avs_byteenable_i[0];
  assign wd = avs_writedata_i[7:0];
  assign tosc_allowed = q_reg.fuse.rc_is_system_clock & tosc_rate_ok(q_reg.sel);

  always_comb begin
    q_next = q_reg;
    q_next.fs1 = fuse_i;
    q_next.fs2 = q_reg.fs1;

    // Bus: one wait cycle, read data captured before the taking edge
    q_next.ack = req & ~q_reg.ack;
    if (avs_read_i & ~q_reg.ack) begin
      q_next.rdata = read_value(avs_address_i, q_reg, tosc_allowed);
    end

    // Unlock window runs down regardless of further unlock writes
    if (q_reg.unlock) begin
      if (q_reg.win_cnt <= 4'h1) begin
        q_next.unlock = 1'b0;
      end else begin
        q_next.win_cnt = q_reg.win_cnt - 4'h1;
      end
    end

    if (wr_fire && reg_hit(avs_address_i, `SCPT_IDX_PRESCALE)) begin
      if (wd == `SCPT_UNLOCK_WORD) begin
        // Unlock only with every other bit zero; no restart while open
        if (!q_reg.unlock) begin
          q_next.unlock = 1'b1;
          q_next.win_cnt = 4'(UNLOCK_CYCLES);
        end
      end else if (!wd[`SCPT_UNLOCK_BIT] && q_reg.unlock) begin
        q_next.unlock = 1'b0;
        // Reserved codes keep the running factor
        if (wd[3:0] <= `SCPT_SEL_MAX) begin
          q_next.sel = wd[3:0];
        end
      end
    end

    if (wr_fire && reg_hit(avs_address_i, `SCPT_IDX_TRIM)) begin
      q_next.trim = wd;
    end

    if (wr_fire && reg_hit(avs_address_i, `SCPT_IDX_CONFIG)) begin
      q_next.tosc_req = wd[`SCPT_CFG_TOSC_REQ];
      q_next.tosc_ext = wd[`SCPT_CFG_TOSC_EXT];
    end

    // Start-up sequencer
    unique case (q_reg.st)
      ST_DELAY, ST_WAKE: begin
        if (q_reg.dly == '0) begin
          q_next.st = ST_RUN;
        end else begin
          q_next.dly = q_reg.dly - `SCPT_DLY_W'(1);
        end
      end
      ST_RUN: begin
        if (deep_sleep_wake_i) begin
          q_next.st = ST_WAKE;
          q_next.dly = `SCPT_DLY_W'(`SCPT_WAKE_CK - 1);
        end
      end
    endcase

    if (srst_i) begin
      q_next.fuse = q_reg.fs2;
      q_next.ack = 1'b0;
      q_next.rdata = 8'h00;
      q_next.unlock = 1'b0;
      q_next.win_cnt = 4'h0;
      q_next.sel = q_reg.fs2.divide_by_eight_config ? `SCPT_SEL_RESET_DIV8
                                                     : `SCPT_SEL_RESET;
      q_next.trim = q_reg.fs2.factory_trim;
      q_next.tosc_req = 1'b0;
      q_next.tosc_ext = 1'b0;
      q_next.st = ST_DELAY;
      q_next.dly = reset_delay(q_reg.fs2.startup_time_config);
    end
  end

  always_ff @(posedge clock_i) begin
    q_reg <= q_next;
  end

  assign avs_waitrequest_o = req & ~q_reg.ack;
  assign avs_readdata_o = {24'h000000, q_reg.rdata};

  // All synchronous domains share one enable so they slow together
  assign domain_clock_enable_o = {4{div_tick & (q_reg.st == ST_RUN)}};
  assign core_clock_o = div_clock;

  // Clock out overrides the port, master clock shown while in reset
  assign clock_output_override_o = srst_i ? q_reg.fs2.clock_output_config
                                          : q_reg.fuse.clock_output_config;
  assign clock_output_pin_o = !clock_output_override_o ? port_pin_data_i :
                              (srst_i ? clock_i : div_clock);

  // Range bit and tuning bits pass straight to the oscillator
  assign rc_oscillator_trim_o = q_reg.trim;

  assign timer_osc_enable_o = q_reg.tosc_req & tosc_allowed;
  assign timer_external_clock_select_o = q_reg.tosc_req & q_reg.tosc_ext & tosc_allowed;
  assign startup_done_o = (q_reg.st == ST_RUN);

endmodule : scpt_top

// ==== hdl/scpt_params.svh ====
/*
  Offsets, field positions, reset values and timing figures of the
  clock prescaler and trim block. Assumes a 40 MHz master clock.
*/
`ifndef SCPT_PARAMS_SVH
`define SCPT_PARAMS_SVH

// Register indices; byte address is four times the index
`define SCPT_IDX_PRESCALE 8'h61
`define SCPT_IDX_TRIM 8'h66
`define SCPT_IDX_CONFIG 8'h70
`define SCPT_IDX_STATUS 8'h71

// Prescale control fields
`define SCPT_UNLOCK_BIT 7
`define SCPT_UNLOCK_WORD 8'h80
`define SCPT_SEL_MAX 4'h8
`define SCPT_SEL_RESET 4'h0
`define SCPT_SEL_RESET_DIV8 4'h3
`define SCPT_UNLOCK_CYCLES 4

// Own config fields
`define SCPT_CFG_TOSC_REQ 0
`define SCPT_CFG_TOSC_EXT 1

// Clock and start-up timing
`define SCPT_CLK_HZ 40000000
`define SCPT_RESET_CK 14
`define SCPT_WAKE_CK 6
`define SCPT_DLY_SHORT_US 4000
`define SCPT_DLY_LONG_US 65000
`define SCPT_DLY_W 22

// Oscillator figures for the timer oscillator check
`define SCPT_RC_HZ 8000000
`define SCPT_TOSC_HZ 32768
`define SCPT_TOSC_RATIO 4

`endif

// ==== hdl/scpt_pkg.sv ====
/*
  Types of the clock prescaler and trim block.
  Assumes scpt_params.svh for field widths.
*/
`include "scpt_params.svh"

package scpt_pkg;

  typedef struct packed {
    logic range_sel;
    logic [6:0] value;
  } scpt_trim_t;

  typedef struct packed {
    logic divide_by_eight_config;
    logic clock_output_config;
    logic [1:0] startup_time_config;
    logic rc_is_system_clock;
    scpt_trim_t factory_trim;
  } scpt_fuse_t;

  typedef struct packed {
    logic io;
    logic adc;
    logic cpu;
    logic flash;
  } scpt_domains_t;

  typedef enum logic [2:0] {
    ST_DELAY = 3'b001,
    ST_RUN = 3'b010,
    ST_WAKE = 3'b100
  } scpt_start_t;

  typedef struct packed {
    scpt_fuse_t fs1;
    scpt_fuse_t fs2;
    scpt_fuse_t fuse;
    logic ack;
    logic [7:0] rdata;
    logic unlock;
    logic [3:0] win_cnt;
    logic [3:0] sel;
    scpt_trim_t trim;
    logic tosc_req;
    logic tosc_ext;
    scpt_start_t st;
    logic [`SCPT_DLY_W-1:0] dly;
  } scpt_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [3:0] cur_sel;
    logic level;
    logic tick;
  } scpt_div_state_t;

endpackage : scpt_pkg

// ==== hdl/scpt_divider.sv ====
/*
  Clock divider: a counter on the undivided clock giving a divided clock
  level and a one-cycle enable per divided period.
  Assumes select_i holds only codes 0 to 8.
*/
`timescale 1ns/100ps

module scpt_divider (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [3:0] select_i,
  output logic tick_o,
  output logic div_clock_o
);
  import scpt_pkg::*;

  scpt_div_state_t q_reg;
  scpt_div_state_t q_next;

  function automatic logic [7:0] last_count(input logic [3:0] code);
    last_count = 8'(9'(9'h001 << code) - 9'h001);
  endfunction : last_count

  function automatic logic [7:0] half_count(input logic [3:0] code);
    half_count = 8'(9'(9'h001 << code) >> 1);
  endfunction : half_count

  always_comb begin
    q_next = q_reg;
    q_next.tick = 1'b0;
    if (q_reg.cnt >= last_count(q_reg.cur_sel)) begin
      // New factor only at a period boundary, so no short pulse appears
      q_next.cnt = 8'h00;
      q_next.cur_sel = select_i;
      q_next.tick = 1'b1;
      q_next.level = 1'b1;
    end else begin
      q_next.cnt = q_reg.cnt + 8'h01;
      q_next.level = (q_next.cnt < half_count(q_reg.cur_sel));
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign tick_o = q_reg.tick;
  // Factor one has no divided level; the master clock itself is passed
  assign div_clock_o = (q_reg.cur_sel == 4'h0) ? clock_i : q_reg.level;

endmodule : scpt_divider

// ==== bench/scpt_props.sv ====
/* Port checker for scpt_top: bus wait, start-up, domains, pin, trim.
   Assumes scpt_pkg is compiled first; bound to every scpt_top. */
`timescale 1ns/100ps
module scpt_props (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire scpt_pkg::scpt_fuse_t fuse_i,
  input wire logic deep_sleep_wake_i,
  input wire logic port_pin_data_i,
  input wire scpt_pkg::scpt_domains_t domain_clock_enable_o,
  input wire logic core_clock_o,
  input wire logic clock_output_pin_o,
  input wire logic clock_output_override_o,
  input wire scpt_pkg::scpt_trim_t rc_oscillator_trim_o,
  input wire logic timer_osc_enable_o,
  input wire logic timer_external_clock_select_o,
  input wire logic startup_done_o
);
  import scpt_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_back;
    !startup_done_o ##[4:8] startup_done_o;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  AST_IDLE_NO_WAIT: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait without request");
  AST_START_HOLD: assert property ($fell(srst_i) |-> !startup_done_o [*8])
    else $error("start-up ended early");
  AST_START_END: assert property ($fell(srst_i) |-> ##[14:40] startup_done_o)
    else $error("start-up never ended");
  AST_WAKE: assert property (deep_sleep_wake_i && startup_done_o |-> ##[1:2] s_back)
    else $error("wake delay wrong");
  AST_NO_EN_START: assert property (!startup_done_o |-> domain_clock_enable_o == 4'h0)
    else $error("clock enable during start-up");
  AST_DOMAINS: assert property (domain_clock_enable_o inside {4'h0, 4'hF})
    else $error("domains not together");
  AST_PIN: assert property (clock_output_override_o |->
    clock_output_pin_o == core_clock_o)
    else $error("pin not the divided clock");
  AST_PIN_PORT: assert property (!clock_output_override_o |->
    clock_output_pin_o == port_pin_data_i)
    else $error("pin not the port value");
  AST_OVR: assert property (
    clock_output_override_o == fuse_i.clock_output_config)
    else $error("override not the strap");
  AST_TRIM: assert property ($fell(srst_i) |->
    rc_oscillator_trim_o == fuse_i.factory_trim)
    else $error("trim not loaded");
  AST_TOSC: assert property (timer_osc_enable_o |-> fuse_i.rc_is_system_clock)
    else $error("timer osc without rc clock");
  AST_EXT: assert property (timer_external_clock_select_o |-> timer_osc_enable_o)
    else $error("external input without timer osc");
endmodule : scpt_props

bind scpt_top scpt_props u_props (.clock_i, .srst_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .fuse_i, .deep_sleep_wake_i, .port_pin_data_i, .domain_clock_enable_o,
  .core_clock_o,
  .clock_output_pin_o, .clock_output_override_o, .rc_oscillator_trim_o, .timer_osc_enable_o,
  .timer_external_clock_select_o, .startup_done_o);

// ==== bench/testbench.sv ====
/* Self-checking bench for scpt_top through its Avalon-MM slave.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/100ps
`include "scpt_params.svh"
module testbench;
  import scpt_pkg::*;
  localparam logic [9:0] A_PS = {`SCPT_IDX_PRESCALE, 2'b00};
  localparam logic [9:0] A_TR = {`SCPT_IDX_TRIM, 2'b00};
  localparam logic [9:0] A_CF = {`SCPT_IDX_CONFIG, 2'b00};
  logic clock_i = 0, srst_i = 1, avs_read_i = 0, avs_write_i = 0, wake = 0, pin_d = 0, t;
  logic [9:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0, rd, avs_readdata_o;
  logic avs_waitrequest_o, core_clock_o, pin_o, ovr_o, tosc_o, ext_o, done_o;
  logic [3:0] sel = 4'h3;
  scpt_domains_t en_o;
  scpt_trim_t trim_o;
  scpt_fuse_t fuse = {1'b1, 1'b1, 2'b00, 1'b1, 8'h5A};
  int miscompares = 0, checks = 0, p;
  localparam int SHORT_DLY = 10;
  logic [3:0] be = 4'hF;
  scpt_top #(.SHORT_DLY_CYCLES(SHORT_DLY), .LONG_DLY_CYCLES(20)) i_dut (
    .clock_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(be), .avs_readdata_o, .avs_waitrequest_o, .fuse_i(fuse),
    .deep_sleep_wake_i(wake), .port_pin_data_i(pin_d), .domain_clock_enable_o(en_o),
    .core_clock_o, .clock_output_pin_o(pin_o), .clock_output_override_o(ovr_o),
    .rc_oscillator_trim_o(trim_o), .timer_osc_enable_o(tosc_o),
    .timer_external_clock_select_o(ext_o), .startup_done_o(done_o));
  initial forever #12.5 clock_i = ~clock_i;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Request stays up until the edge that sees waitrequest low; the next call replaces it
  task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
  endtask : acc
  task rdc(input logic [9:0] a, input logic [7:0] e, input string n);
    acc(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rd);
  endtask : rdc
  task idle(input int k);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    repeat (k) @(posedge clock_i);
  endtask : idle
  // Spacing of enable pulses, last of three
  task per(input int e);
    for (int i = 0; i < 3; i++) begin
      p = 0;
      do begin
        @(negedge clock_i);
        p++;
      end while (en_o !== 4'hF && p < 600);
    end
    chk("period", e, p);
    @(posedge clock_i);
  endtask : per
  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (41) @(posedge clock_i);
    rdc(A_PS, 8'h03, "select reset");
    rdc(A_TR, 8'h5A, "trim reset");
    acc(1'b1, A_CF, 8'h03);
    $display("reset test done");
    // Both steps back to back, nothing may come between them
    for (int c = 0; c < 10; c++) begin
      acc(1'b1, A_PS, 8'h80);
      acc(1'b1, A_PS, c[7:0]);
      if (c < 9) sel = c[3:0];
      rdc(A_PS, {4'h0, sel}, "select");
      idle(1);
      per(1 << sel);
      t = (`SCPT_RC_HZ >> sel) >= `SCPT_TOSC_RATIO * `SCPT_TOSC_HZ;
      chk("timer osc", {30'h0, t, t}, {30'h0, ext_o, tosc_o});
    end
    $display("select test done");
    acc(1'b1, A_PS, 8'h05);
    rdc(A_PS, 8'h08, "no unlock");
    acc(1'b1, A_PS, 8'h81);
    rdc(A_PS, 8'h08, "unlock with extra bits");
    acc(1'b1, A_PS, 8'h80);
    rdc(A_PS, 8'h88, "window open");
    idle(3);
    acc(1'b1, A_PS, 8'h05);
    rdc(A_PS, 8'h08, "window expired");
    acc(1'b1, A_PS, 8'h80);
    idle(1);
    acc(1'b1, A_PS, 8'h80);
    acc(1'b1, A_PS, 8'h05);
    rdc(A_PS, 8'h08, "no restart");
    $display("window test done");
    // No memory writes run here, so any trim value is safe
    acc(1'b1, A_TR, 8'h7F);
    rdc(A_TR, 8'h7F, "trim");
    chk("trim port", 32'h7F, trim_o);
    be <= 4'hE;
    acc(1'b1, A_TR, 8'h11);
    be <= 4'hF;
    rdc(A_TR, 8'h7F, "byte lane off");
    acc(1'b1, 10'h3FC, 8'hFF);
    rdc(10'h3FC, 8'h00, "unmapped");
    idle(1);
    pin_d <= 1'b1;
    wake <= 1'b1;
    @(posedge clock_i);
    wake <= 1'b0;
    repeat (`SCPT_WAKE_CK - 1) @(posedge clock_i);
    @(negedge clock_i);
    chk("wake hold", 32'h0, done_o);
    @(negedge clock_i);
    chk("done after wake", 32'h1, done_o);
    $display("trim and wake test done");
    // Second reset with every strap flipped but the high bit of startup_time_config
    @(posedge clock_i);
    srst_i <= 1'b1;
    fuse <= {1'b0, 1'b0, 2'b01, 1'b0, 8'hA5};
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (`SCPT_RESET_CK + SHORT_DLY - 1) @(posedge clock_i);
    @(negedge clock_i);
    chk("delay hold", 32'h0, done_o);
    @(negedge clock_i);
    chk("delay end", 32'h1, done_o);
    @(posedge clock_i);
    rdc(A_PS, 8'h00, "select reset plain");
    rdc(A_TR, 8'hA5, "trim reset again");
    chk("pin port", 32'h1, pin_o);
    chk("override", 32'h0, ovr_o);
    acc(1'b1, A_CF, 8'h03);
    idle(1);
    chk("timer osc off", 32'h0, {30'h0, ext_o, tosc_o});
    $display("second reset test done");
    finish_test();
  end
endmodule : testbench
